// ### hdl/divider_cfg_ctrl.sv
// divider configuration controller driving the transceiver dynamic_config_port
// Behaviour
// - transmit output divider 0x7C bits 10:8
// - receive output divider 0x63 bits 2:0
// - quad A feedback 0x14, value minus two
// - quad B feedback 0x94, value minus two
// - quad A reference 0x18 bits 11:7
// - quad B reference 0x98 bits 11:7
// - quad A rate select 0x0E bit 0
// - channel second feedback 0x28 bits 15:8
// - channel first feedback 0x28 bit 7
// - channel reference divider 0x2A bits 15:11
// - refuse quad divides outside supported sets
// - refuse channel divides outside supported sets
// - fractional multiplier fixed at one
// - line rate twice pll out over divider
// - read, replace field bits, write back
`timescale 1ns/100ps
`include "divider_cfg_defs.svh"

module divider_cfg_ctrl #(
  parameter logic [15:0] TIMEOUT_CYC = `RESP_TIMEOUT
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_field,
  input  wire logic [8:0]  cmd_raw_addr,
  input  wire logic [15:0] cmd_value,
  output logic             cmd_busy,
  output logic             cmd_done,
  output logic             cmd_error,
  output logic             cmd_refused,
  output logic [15:0]      cmd_readback,
  output logic             dcp_en,
  output logic             dcp_we,
  output logic [8:0]       dcp_addr,
  output logic [15:0]      dcp_di,
  input  wire logic [15:0] dcp_do,
  input  wire logic        dcp_rdy
);

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [1:0]  rdy_sync_r;
  logic [15:0] do_s1_r;
  logic [15:0] do_s2_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // data is sampled with the ready level, both two stages deep, so they stay aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_sync_r <= 2'h0;
      do_s1_r    <= 16'h0000;
      do_s2_r    <= 16'h0000;
    end else begin
      rdy_sync_r <= {rdy_sync_r[0], dcp_rdy};
      do_s1_r    <= dcp_do;
      do_s2_r    <= do_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // field encoding
  // ----------------------------------------------------------------
  // output divider: 1,2,4,8,16,32 -> 0..5; ok flag reports legality
  function automatic logic [16:0] enc_outdiv(input logic [15:0] d, input logic chan);
    logic [15:0] c;
    logic        ok;
    c  = 16'h0000;
    ok = 1'b1;
    unique case (d)
      16'h0001: c = 16'h0000;
      16'h0002: c = 16'h0001;
      16'h0004: c = 16'h0002;
      16'h0008: c = 16'h0003;
      16'h0010: c = 16'h0004;
      16'h0020: c = 16'h0005;
      default:  ok = 1'b0;
    endcase
    if (chan && d > 16'h0008) begin
      ok = 1'b0;
    end
    return {ok, c};
  endfunction

  // small reference/feedback stage: 1 -> 16, n -> n-2, up to lim
  function automatic logic [16:0] enc_small(input logic [15:0] d, input logic [15:0] lim);
    logic [15:0] c;
    c = (d == 16'h0001) ? {8'h00, `DIV_ONE_CODE} : d - 16'h0002;
    return {(d != 16'h0000) && (d <= lim), c};
  endfunction

  function automatic logic fb_legal(input logic [15:0] d);
    unique case (d)
      16'd16, 16'd20, 16'd32, 16'd40, 16'd60, 16'd64, 16'd66, 16'd75,
      16'd80, 16'd84, 16'd90, 16'd96, 16'd100, 16'd112, 16'd120,
      16'd125, 16'd150: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  logic [16:0] enc;
  logic [8:0]  f_addr;
  logic [15:0] f_mask;
  logic [4:0]  f_shift;

  always_comb begin
    enc     = 17'h00000;
    f_addr  = cmd_raw_addr;
    f_mask  = `MASK_FULL;
    f_shift = 5'h00;
    unique case (divider_cfg_pkg::field_t'(cmd_field))
      divider_cfg_pkg::FLD_TX_OUTDIV: begin
        enc = enc_outdiv(cmd_value, 1'b0);
        f_addr = `ADDR_TX_OUTDIV;
        f_mask = `MASK_TX_OUTDIV;
        f_shift = `SHIFT_TX_OUTDIV;
      end
      divider_cfg_pkg::FLD_RX_OUTDIV: begin
        enc = enc_outdiv(cmd_value, 1'b0);
        f_addr = `ADDR_RX_OUTDIV;
        f_mask = `MASK_RX_OUTDIV;
        f_shift = `SHIFT_RX_OUTDIV;
      end
      divider_cfg_pkg::FLD_QA_FBDIV, divider_cfg_pkg::FLD_QB_FBDIV: begin
        enc = {fb_legal(cmd_value), cmd_value - {8'h00, `FBDIV_OFFSET}};
        f_addr = (cmd_field == divider_cfg_pkg::FLD_QA_FBDIV) ? `ADDR_QA_FBDIV
                                                              : `ADDR_QB_FBDIV;
        f_mask = `MASK_Q_FBDIV;
        f_shift = `SHIFT_Q_FBDIV;
      end
      divider_cfg_pkg::FLD_QA_REFDIV, divider_cfg_pkg::FLD_QB_REFDIV: begin
        enc = enc_small(cmd_value, 16'h0004);
        f_addr = (cmd_field == divider_cfg_pkg::FLD_QA_REFDIV) ? `ADDR_QA_REFDIV
                                                               : `ADDR_QB_REFDIV;
        f_mask = `MASK_Q_REFDIV;
        f_shift = `SHIFT_Q_REFDIV;
      end
      divider_cfg_pkg::FLD_QA_RATE: begin
        // factor 2 is half rate (0), factor 1 full rate (1)
        enc = {(cmd_value == 16'h0001) || (cmd_value == 16'h0002),
               15'h0000, cmd_value == 16'h0001};
        f_addr = `ADDR_QA_RATE;
        f_mask = `MASK_Q_RATE;
        f_shift = `SHIFT_Q_RATE;
      end
      divider_cfg_pkg::FLD_CH_FB2: begin
        enc = enc_small(cmd_value, 16'h0005);
        f_addr = `ADDR_CH_FBDIV;
        f_mask = `MASK_CH_FB2;
        f_shift = `SHIFT_CH_FB2;
      end
      divider_cfg_pkg::FLD_CH_FB1: begin
        enc = {(cmd_value == 16'h0004) || (cmd_value == 16'h0005),
               15'h0000, cmd_value == 16'h0005};
        f_addr = `ADDR_CH_FBDIV;
        f_mask = `MASK_CH_FB1;
        f_shift = `SHIFT_CH_FB1;
      end
      divider_cfg_pkg::FLD_CH_REFDIV: begin
        enc = enc_small(cmd_value, 16'h0002);
        f_addr = `ADDR_CH_REFDIV;
        f_mask = `MASK_CH_REFDIV;
        f_shift = `SHIFT_CH_REFDIV;
      end
      divider_cfg_pkg::FLD_RAW_WORD: begin
        enc = {1'b1, cmd_value};
      end
      default: begin
        enc = 17'h00000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // read-modify-write sequencer
  // ----------------------------------------------------------------
  divider_cfg_pkg::ctl_t s_r;
  divider_cfg_pkg::ctl_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.en   = 1'b0;
    s_nxt.bad  = 1'b0;
    unique case (s_r.st)
      divider_cfg_pkg::ST_IDLE: begin
        // the cycle after done is no take slot, so a held request never runs twice
        if (cmd_valid && !s_r.done) begin
          if (!enc[16]) begin
            s_nxt.bad = 1'b1;
          end else begin
            s_nxt.addr = f_addr;
            s_nxt.mask = f_mask;
            s_nxt.val  = (enc[15:0] << f_shift) & f_mask;
            s_nxt.busy = 1'b1;
            s_nxt.err  = 1'b0;
            s_nxt.st   = (f_mask == `MASK_FULL) ? divider_cfg_pkg::ST_WR
                                                : divider_cfg_pkg::ST_RD;
          end
        end
      end
      divider_cfg_pkg::ST_RD: begin
        if (!rdy_sync_r[1]) begin
          s_nxt.en  = 1'b1;
          s_nxt.we  = 1'b0;
          s_nxt.tmo = 16'h0000;
          s_nxt.st  = divider_cfg_pkg::ST_RDW;
        end
      end
      divider_cfg_pkg::ST_RDW: begin
        s_nxt.tmo = s_r.tmo + 16'h0001;
        if (rdy_sync_r[1]) begin
          // keep neighbouring fields, replace only the target bits
          s_nxt.val   = (do_s2_r & ~s_r.mask) | s_r.val;
          s_nxt.rdata = do_s2_r;
          s_nxt.st    = divider_cfg_pkg::ST_WR;
        end else if (s_r.tmo == TIMEOUT_CYC) begin
          s_nxt.err  = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.st   = divider_cfg_pkg::ST_IDLE;
        end
      end
      divider_cfg_pkg::ST_WR: begin
        // wait until the previous ready has dropped before a new access
        if (!rdy_sync_r[1]) begin
          s_nxt.en  = 1'b1;
          s_nxt.we  = 1'b1;
          s_nxt.di  = s_r.val;
          s_nxt.tmo = 16'h0000;
          s_nxt.st  = divider_cfg_pkg::ST_WRW;
        end
      end
      divider_cfg_pkg::ST_WRW: begin
        s_nxt.tmo = s_r.tmo + 16'h0001;
        if (rdy_sync_r[1] || s_r.tmo == TIMEOUT_CYC) begin
          s_nxt.err  = !rdy_sync_r[1];
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.we   = 1'b0;
          s_nxt.st   = divider_cfg_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt = s_r;
        s_nxt.st = divider_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: divider_cfg_pkg::ST_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_busy     = s_r.busy;
  assign cmd_done     = s_r.done;
  assign cmd_error    = s_r.err;
  assign cmd_refused  = s_r.bad;
  assign cmd_readback = s_r.rdata;
  assign dcp_en       = s_r.en;
  assign dcp_we       = s_r.we;
  assign dcp_addr     = s_r.addr;
  assign dcp_di       = s_r.di;
  // no fractional or rate arithmetic is performed here; the
  // modulator words are only ever written whole as raw words

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  one_access_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.en |=> !s_r.en [*2]) else $error("port strobe repeated");
  strobe_after_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.en |-> $past(!rdy_sync_r[1])) else $error("strobe while ready high");
  merge_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == divider_cfg_pkg::ST_RDW && rdy_sync_r[1]) |=>
      ((s_r.val & ~s_r.mask) == (s_r.rdata & ~s_r.mask)))
    else $error("neighbour bits changed");
  read_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.mask != `MASK_FULL) |->
      $past(s_r.st, 2) != divider_cfg_pkg::ST_IDLE)
    else $error("partial write without read");
  refuse_bad_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.bad |-> (s_r.st == divider_cfg_pkg::ST_IDLE && !s_r.busy && !s_r.en))
    else $error("illegal divide accepted");
  tx_field_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.addr == `ADDR_TX_OUTDIV && s_r.mask == `MASK_TX_OUTDIV)
      |-> s_r.di[10:8] <= 3'h5) else $error("transmit divider code out of range");
  rx_field_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.addr == `ADDR_RX_OUTDIV && s_r.mask == `MASK_RX_OUTDIV)
      |-> s_r.di[2:0] <= 3'h5) else $error("receive divider code out of range");
  fb_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == divider_cfg_pkg::ST_IDLE && cmd_valid && !s_r.done && enc[16] &&
     cmd_field == divider_cfg_pkg::FLD_QA_FBDIV) |=>
      s_r.val[7:0] == 8'($past(cmd_value) - 16'h0002))
    else $error("feedback code not minus two");
  fb_b_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == divider_cfg_pkg::ST_IDLE && cmd_valid && !s_r.done && enc[16] &&
     cmd_field == divider_cfg_pkg::FLD_QB_FBDIV) |=>
      s_r.val[7:0] == 8'($past(cmd_value) - 16'h0002))
    else $error("quad B feedback code not minus two");
  ref_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.mask == `MASK_Q_REFDIV) |->
      (s_r.di[11:7] inside {5'h10, 5'h00, 5'h01, 5'h02}))
    else $error("quad reference code out of range");
  rate_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.mask == `MASK_Q_RATE) |-> s_r.addr == `ADDR_QA_RATE)
    else $error("rate select written elsewhere");
  ch_fb2_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.mask == `MASK_CH_FB2) |-> (s_r.addr == `ADDR_CH_FBDIV &&
      (s_r.di[15:8] inside {8'h10, 8'h00, 8'h01, 8'h02, 8'h03})))
    else $error("channel second stage code out of range");
  ch_fb1_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.mask == `MASK_CH_FB1) |-> s_r.addr == `ADDR_CH_FBDIV)
    else $error("channel first stage written elsewhere");
  ch_ref_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.en && s_r.we && s_r.mask == `MASK_CH_REFDIV) |-> (s_r.addr == `ADDR_CH_REFDIV &&
      (s_r.di[15:11] inside {5'h10, 5'h00})))
    else $error("channel reference code out of range");
  wait_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == divider_cfg_pkg::ST_RDW || s_r.st == divider_cfg_pkg::ST_WRW) |->
      s_r.tmo <= TIMEOUT_CYC)
    else $error("port wait past its limit");
  done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.done |=> !s_r.done && !s_r.busy) else $error("done not a pulse");
endmodule

// ### hdl/divider_cfg_defs.svh
// addresses, field positions and encodings of the divider configuration map
`ifndef DIVIDER_CFG_DEFS_SVH
`define DIVIDER_CFG_DEFS_SVH
`define ADDR_QA_CFG0      9'h008
`define ADDR_SHARED_A     9'h009
`define ADDR_QA_RATE      9'h00E
`define ADDR_QA_CFG1      9'h010
`define ADDR_QA_CFG2      9'h011
`define ADDR_QA_FBDIV     9'h014
`define ADDR_QA_REFDIV    9'h018
`define ADDR_CH_FBDIV     9'h028
`define ADDR_CH_REFDIV    9'h02A
`define ADDR_CH_INIT      9'h02B
`define ADDR_RX_OUTDIV    9'h063
`define ADDR_TX_OUTDIV    9'h07C
`define ADDR_QB_CFG0      9'h088
`define ADDR_SHARED_B     9'h089
`define ADDR_QB_CFG1      9'h090
`define ADDR_QB_CFG2      9'h091
`define ADDR_QB_FBDIV     9'h094
`define ADDR_QB_REFDIV    9'h098
`define MASK_TX_OUTDIV    16'h0700
`define SHIFT_TX_OUTDIV   5'h08
`define MASK_RX_OUTDIV    16'h0007
`define SHIFT_RX_OUTDIV   5'h00
`define MASK_Q_FBDIV      16'h00FF
`define SHIFT_Q_FBDIV     5'h00
`define MASK_Q_REFDIV     16'h0F80
`define SHIFT_Q_REFDIV    5'h07
`define MASK_Q_RATE       16'h0001
`define SHIFT_Q_RATE      5'h00
`define MASK_CH_FB2       16'hFF00
`define SHIFT_CH_FB2      5'h08
`define MASK_CH_FB1       16'h0080
`define SHIFT_CH_FB1      5'h07
`define MASK_CH_REFDIV    16'hF800
`define SHIFT_CH_REFDIV   5'h0B
`define MASK_FULL         16'hFFFF
`define FBDIV_OFFSET      8'h02
`define DIV_ONE_CODE      8'h10
`define RESP_TIMEOUT      16'h03E8
`endif

// ### hdl/divider_cfg_pkg.sv
// types shared by the divider configuration controller
package divider_cfg_pkg;
  typedef enum logic [3:0] {
    FLD_TX_OUTDIV = 4'h0,
    FLD_RX_OUTDIV = 4'h1,
    FLD_QA_FBDIV  = 4'h2,
    FLD_QB_FBDIV  = 4'h3,
    FLD_QA_REFDIV = 4'h4,
    FLD_QB_REFDIV = 4'h5,
    FLD_QA_RATE   = 4'h6,
    FLD_CH_FB2    = 4'h7,
    FLD_CH_FB1    = 4'h8,
    FLD_CH_REFDIV = 4'h9,
    FLD_RAW_WORD  = 4'hA
  } field_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RD    = 5'h02,
    ST_RDW   = 5'h04,
    ST_WR    = 5'h08,
    ST_WRW   = 5'h10
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [8:0]  addr;
    logic [15:0] mask;
    logic [15:0] val;
    logic [15:0] rdata;
    logic [15:0] tmo;
    logic        en;
    logic        we;
    logic [15:0] di;
    logic        busy;
    logic        done;
    logic        err;
    logic        bad;
  } ctl_t;
endpackage

// ### test/dcp_device_model.sv
// behavioural model of the transceiver dynamic_config_port and its register words
`timescale 1ns/100ps
module dcp_device_model (
  input  wire logic        clk,
  input  wire logic        dcp_en,
  input  wire logic        dcp_we,
  input  wire logic [8:0]  dcp_addr,
  input  wire logic [15:0] dcp_di,
  output logic      [15:0] dcp_do,
  output logic             dcp_rdy,
  input  wire logic [7:0]  delay,
  input  wire logic        mute
);
  logic [15:0] mem [0:511];
  logic [8:0]  a;
  logic        w;
  logic [15:0] d;
  initial begin
    // odd start pattern so that a merge which clobbers neighbours shows up
    for (int i = 0; i < 512; i++) mem[i] = 16'hA5C3 ^ 16'(i * 16'h0111);
    dcp_rdy = 1'b0;
    dcp_do = 16'h0000;
    forever begin
      @(posedge clk);
      if (dcp_en === 1'b1 && mute !== 1'b1) begin
        a = dcp_addr;
        w = dcp_we;
        d = dcp_di;
        repeat (delay) @(posedge clk);
        #1;
        // whole 16-bit words kept per address, fields sit where the map puts them
        if (w) mem[a] = d;
        dcp_do = w ? ~mem[a] : mem[a];
        dcp_rdy = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        dcp_rdy = 1'b0;
        // data is not held once ready drops
        dcp_do = ~dcp_do;
      end
    end
  end
endmodule

// ### test/divider_cfg_ctrl_bench.sv
// self-checking bench for the divider configuration controller
`timescale 1ns/100ps
module divider_cfg_ctrl_bench;
  logic        clk, reset_n, cmd_valid, mute, pend, got_done, got_ref;
  logic [3:0]  cmd_field;
  logic [8:0]  cmd_raw_addr, dcp_addr, last_addr;
  logic [15:0] cmd_value, cmd_readback, dcp_di, dcp_do;
  logic        cmd_busy, cmd_done, cmd_error, cmd_refused, dcp_en, dcp_we, dcp_rdy;
  logic [7:0]  delay;
  int          error_cnt, tests_run, rd_cnt, wr_cnt;

  divider_cfg_ctrl #(.TIMEOUT_CYC(16'h0014)) dut (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_field(cmd_field), .cmd_raw_addr(cmd_raw_addr),
    .cmd_value(cmd_value), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_error(cmd_error),
    .cmd_refused(cmd_refused), .cmd_readback(cmd_readback), .dcp_en(dcp_en), .dcp_we(dcp_we),
    .dcp_addr(dcp_addr), .dcp_di(dcp_di), .dcp_do(dcp_do), .dcp_rdy(dcp_rdy));
  dcp_device_model model (.clk(clk), .dcp_en(dcp_en), .dcp_we(dcp_we), .dcp_addr(dcp_addr),
    .dcp_di(dcp_di), .dcp_do(dcp_do), .dcp_rdy(dcp_rdy), .delay(delay), .mute(mute));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  // --------------------------------------------------------------
  // port monitor
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (dcp_en === 1'b1) begin
      check(!(pend && !mute), "access while previous one open");
      pend = 1'b1;
      if (dcp_we === 1'b1) wr_cnt++;
      else rd_cnt++;
      last_addr = dcp_addr;
    end
  end
  always @(negedge dcp_rdy) pend = 1'b0;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic issue(input logic [3:0] f, input logic [15:0] v, input logic [8:0] a);
    int n;
    n = 0;
    rd_cnt = 0;
    wr_cnt = 0;
    got_done = 1'b0;
    got_ref = 1'b0;
    @(posedge clk);
    #1;
    cmd_field = f;
    cmd_value = v;
    cmd_raw_addr = a;
    cmd_valid = 1'b1;
    while (!got_done && !got_ref && n < 200) begin
      @(posedge clk);
      #1;
      n++;
      if (cmd_busy === 1'b1 || cmd_refused === 1'b1) cmd_valid = 1'b0;
      if (cmd_done === 1'b1) got_done = 1'b1;
      if (cmd_refused === 1'b1) got_ref = 1'b1;
    end
    if (!got_done && !got_ref) begin
      check(1'b0, "no completion");
      report_and_stop();
    end
  endtask

  task automatic fld(input logic [3:0] f, input logic [15:0] v, input logic [8:0] a,
                     input logic [15:0] m, input logic [15:0] bits);
    logic [15:0] pre;
    pre = model.mem[a];
    issue(f, v, 9'h000);
    check(got_done && rd_cnt == 1 && wr_cnt == 1 && last_addr === a, "field sequence");
    check(cmd_readback === pre && cmd_error === 1'b0, "read phase");
    check(model.mem[a] === ((pre & ~m) | bits), "field merge");
  endtask

  task automatic raw(input logic [8:0] a, input logic [15:0] v);
    issue(4'hA, v, a);
    check(got_done && rd_cnt == 0 && wr_cnt == 1 && model.mem[a] === v, "raw word");
  endtask

  task automatic refuse(input logic [3:0] f, input logic [15:0] v);
    issue(f, v, 9'h000);
    check(got_ref && !got_done && rd_cnt == 0 && wr_cnt == 0, "illegal divide taken");
  endtask

  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_field = 4'h0;
    cmd_raw_addr = 9'h000;
    cmd_value = 16'h0000;
    mute = 1'b0;
    delay = 8'h00;
    pend = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    rd_cnt = 0;
    wr_cnt = 0;
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 check(cmd_busy === 1'b0 && cmd_done === 1'b0 && dcp_en === 1'b0, "idle after reset");
    fld(4'h0, 16'h0020, 9'h07C, 16'h0700, 16'h0500);
    fld(4'h0, 16'h0001, 9'h07C, 16'h0700, 16'h0000);
    fld(4'h1, 16'h0010, 9'h063, 16'h0007, 16'h0004);
    fld(4'h1, 16'h0002, 9'h063, 16'h0007, 16'h0001);
    fld(4'h2, 16'h0064, 9'h014, 16'h00FF, 16'h0062);
    fld(4'h3, 16'h0010, 9'h094, 16'h00FF, 16'h000E);
    fld(4'h3, 16'h0042, 9'h094, 16'h00FF, 16'h0040);
    fld(4'h4, 16'h0001, 9'h018, 16'h0F80, 16'h0800);
    fld(4'h5, 16'h0004, 9'h098, 16'h0F80, 16'h0100);
    fld(4'h5, 16'h0003, 9'h098, 16'h0F80, 16'h0080);
    fld(4'h6, 16'h0001, 9'h00E, 16'h0001, 16'h0001);
    fld(4'h6, 16'h0002, 9'h00E, 16'h0001, 16'h0000);
    delay = 8'h06;
    fld(4'h7, 16'h0005, 9'h028, 16'hFF00, 16'h0300);
    fld(4'h7, 16'h0001, 9'h028, 16'hFF00, 16'h1000);
    fld(4'h8, 16'h0005, 9'h028, 16'h0080, 16'h0080);
    fld(4'h8, 16'h0004, 9'h028, 16'h0080, 16'h0000);
    fld(4'h9, 16'h0001, 9'h02A, 16'hF800, 16'h8000);
    fld(4'h9, 16'h0002, 9'h02A, 16'hF800, 16'h0000);
    delay = 8'h00;
    raw(9'h02B, 16'hFFFF);
    raw(9'h091, 16'h0000);
    raw(9'h008, 16'h1234);
    refuse(4'h4, 16'h0005);
    refuse(4'h6, 16'h0003);
    refuse(4'h2, 16'h0011);
    refuse(4'h9, 16'h0003);
    refuse(4'h7, 16'h0006);
    refuse(4'h8, 16'h0003);
    refuse(4'h0, 16'h0003);
    // silent port: the sequence must give up and flag it
    mute = 1'b1;
    issue(4'h1, 16'h0008, 9'h000);
    check(got_done && cmd_error === 1'b1, "timeout not flagged");
    repeat (8) @(posedge clk);
    #1 mute = 1'b0;
    pend = 1'b0;
    fld(4'h1, 16'h0008, 9'h063, 16'h0007, 16'h0003);
    report_and_stop();
  end
endmodule
